// ---- dv/mlp_peer.sv ----
// Peer radio model: counts frames from the block and sends frames to it
module mlp_peer
	import mlp_pkg::*;
(
	// Clock and control
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic stall_i,
	// Frames from the block
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic [1:0] tx_type_i,
	input wire logic [7:0] tx_seq_i,
	input wire logic [31:0] tx_data_i,
	input wire logic [31:0] tx_crc_i,
	// Frames to the block
	output logic rx_valid_o,
	output logic [1:0] rx_type_o,
	output logic [7:0] rx_seq_o,
	output logic [31:0] rx_data_o,
	output logic [31:0] rx_crc_o,
	// Frame counts and sequence of the last frame
	output int n_out_o,
	output int n_ret_o,
	output int n_ack_o,
	output int n_bad_o,
	output logic [7:0] seq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ph = 0;
	initial begin
		tx_ready_o = 1;
		{rx_valid_o, rx_type_o, rx_seq_o, rx_data_o, rx_crc_o} = '0;
	end
	// Same frame format and check on every unit
	function automatic logic [31:0] crc(input logic [41:0] d);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 41; i >= 0; i--) begin
			c = (c << 1) ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h00000000);
		end
		return ~c;
	endfunction
	// Ready every cycle, or every other one when stalling
	always @(posedge clk_i) begin
		ph <= ~ph;
		tx_ready_o <= !stall_i || ph;
	end
	always @(posedge clk_i) begin
		if (clr_i) begin
			{n_out_o, n_ret_o, n_ack_o, n_bad_o} <= '0;
		end else if (tx_valid_i === 1'b1 && tx_ready_o) begin
			n_out_o <= n_out_o + int'(tx_type_i === FT_OUT);
			n_ret_o <= n_ret_o + int'(tx_type_i === FT_RET);
			n_ack_o <= n_ack_o + int'(tx_type_i === FT_ACK);
			n_bad_o <= n_bad_o + int'(tx_crc_i !== crc({tx_type_i, tx_seq_i, tx_data_i}));
			seq_o <= tx_seq_i;
		end
	end
	// One frame strobe, then the inverse of the last frame
	task automatic send(input logic [1:0] t, input logic [7:0] s, input logic [31:0] d,
		input logic good);
		logic [31:0] c;
		c = crc({t, s, d}) ^ {32{!good}};
		@(posedge clk_i);
		{rx_valid_o, rx_type_o, rx_seq_o, rx_data_o, rx_crc_o} <= {1'b1, t, s, d, c};
		@(posedge clk_i);
		{rx_valid_o, rx_type_o, rx_seq_o, rx_data_o, rx_crc_o} <= {1'b0, ~t, ~s, ~d, ~c};
	endtask
endmodule

// ---- dv/tb_top.sv ----
// Testbench for the multipoint link framer
module tb_top import mlp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, rst_i, cyc, stb, we, sin_v, clr, stall, ack, sin_r, sout_v, tx_v, tx_r, rx_v;
	logic [1:0] tx_t, rx_t;
	logic [3:0] sel;
	logic [7:0] adr, tx_s, rx_s, pseq;
	logic [31:0] wdat, rdat, q, sin_d, sout_d, ser_last, tx_d, tx_c, rx_d, rx_c, tx_last;
	int fail_count, cmp_count, n_ser, n_out, n_ret, n_ack, n_bad, n1;
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (clr) begin
			n_ser <= 0;
		end else if (sout_v === 1'b1) begin
			n_ser <= n_ser + 1;
			ser_last <= sout_d;
		end
	end
	always @(posedge clk_i) begin
		if (tx_v === 1'b1 && tx_r === 1'b1) begin
			tx_last <= tx_d;
		end
	end
	mlp_link dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ser_in_valid_i(sin_v), .ser_in_ready_o(sin_r), .ser_in_data_i(sin_d),
		.ser_out_valid_o(sout_v), .ser_out_data_o(sout_d), .rf_tx_valid_o(tx_v),
		.rf_tx_ready_i(tx_r), .rf_tx_type_o(tx_t), .rf_tx_seq_o(tx_s), .rf_tx_data_o(tx_d),
		.rf_tx_crc_o(tx_c), .rf_rx_valid_i(rx_v), .rf_rx_type_i(rx_t), .rf_rx_seq_i(rx_s),
		.rf_rx_data_i(rx_d), .rf_rx_crc_i(rx_c));
	mlp_peer peer (.clk_i(clk_i), .clr_i(clr), .stall_i(stall), .tx_valid_i(tx_v),
		.tx_ready_o(tx_r), .tx_type_i(tx_t), .tx_seq_i(tx_s), .tx_data_i(tx_d), .tx_crc_i(tx_c),
		.rx_valid_o(rx_v), .rx_type_o(rx_t), .rx_seq_o(rx_s), .rx_data_o(rx_d), .rx_crc_o(rx_c),
		.n_out_o(n_out), .n_ret_o(n_ret), .n_ack_o(n_ack), .n_bad_o(n_bad), .seq_o(pseq));
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic tmo();
		fail_count++;
		$display("mismatch wait expected done seen timeout");
		stop_test();
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		{cyc, stb} <= 2'b00;
		if (n >= 20) tmo();
	endtask
	task automatic clear();
		@(posedge clk_i);
		clr <= 1;
		@(posedge clk_i);
		clr <= 0;
	endtask
	task automatic reset();
		rst_i <= 1;
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		clear();
	endtask
	task automatic push(input logic [31:0] w);
		int n;
		n = 0;
		@(posedge clk_i);
		{sin_v, sin_d} <= {1'b1, w};
		do begin
			@(posedge clk_i);
			n++;
		end while (sin_r !== 1'b1 && n < 20);
		sin_v <= 0;
		if (n >= 20) tmo();
	endtask
	task automatic tx_done();
		for (int n = 0; tx_v !== 1'b1; n++) begin
			if (n > 3000) tmo();
			@(posedge clk_i);
		end
		for (int n = 0; tx_v !== 1'b0; n++) begin
			if (n > 3000) tmo();
			@(posedge clk_i);
		end
		@(posedge clk_i);
	endtask
	task automatic t_regs();
		wb(0, ADR_CTRL, 0);
		chk("ctrl reset", 32'h00000003, q);
		wb(0, ADR_CFG, 0);
		chk("cfg reset", 32'h00090903, q);
		wb(0, 8'h10, 0);
		chk("unmapped", 32'h00000000, q);
		wb(1, ADR_CFG, 32'h000F0F0C);
		wb(0, ADR_CFG, 0);
		chk("cfg clamp", 32'h00090909, q);
		wb(1, ADR_CTRL, 32'h00000107);
		wb(0, ADR_CTRL, 0);
		chk("presence", 32'h00000107, q);
	endtask
	task automatic t_master();
		wb(1, ADR_CTRL, 32'h00000002);
		for (int r = 0; r <= 9; r += 9) begin
			wb(1, ADR_CFG, 32'h00090900 | r);
			stall <= (r == 9);
			clear();
			push(32'hA5A50000 + r);
			tx_done();
			chk("copies", r + 1, n_out);
			chk("tx data", 32'hA5A50000 + r, tx_last);
			chk("crc errors", 0, n_bad);
			chk("returns", 0, n_ret);
		end
		stall <= 0;
	endtask
	task automatic t_slave();
		reset();
		peer.send(FT_OUT, 8'h05, 32'h12345678, 1'b0);
		peer.send(FT_OUT, 8'h05, 32'h12345678, 1'b1);
		peer.send(FT_OUT, 8'h05, 32'h12345678, 1'b1);
		repeat (4) @(posedge clk_i);
		chk("delivered", 1, n_ser);
		chk("data", 32'h12345678, ser_last);
		chk("frames sent", 0, n_out + n_ret + n_ack);
		wb(0, ADR_CNT, 0);
		chk("duplicates", 1, q[15:0]);
	endtask
	task automatic t_rep();
		wb(1, ADR_CTRL, 32'h00000007);
		wb(1, ADR_CFG, 32'h00090902);
		wb(1, ADR_CNT, 0);
		clear();
		peer.send(FT_OUT, 8'h09, 32'hFEED0009, 1'b1);
		tx_done();
		peer.send(FT_OUT, 8'h09, 32'hFEED0009, 1'b1);
		peer.send(FT_OUT, 8'h09, 32'hFEED0009, 1'b1);
		repeat (4) @(posedge clk_i);
		chk("forwards", 3, n_out);
		chk("fwd data", 32'hFEED0009, tx_last);
		wb(0, ADR_CNT, 0);
		chk("dropped", 2, q[15:0]);
		clear();
		peer.send(FT_RET, 8'h21, 32'h0BAD0021, 1'b1);
		tx_done();
		chk("acks", 1, n_ack);
		chk("ack seq", 8'h21, pseq);
		chk("ret data", 32'h0BAD0021, ser_last);
	endtask
	task automatic t_ret();
		reset();
		push(32'hC0DE0001);
		for (int n = 0; n_ret == 0; n++) begin
			if (n > 100) tmo();
			@(posedge clk_i);
		end
		peer.send(FT_ACK, pseq, 0, 1'b1);
		repeat (2 * ACK_WAIT_CYC) @(posedge clk_i);
		chk("acked returns", 1, n_ret);
	endtask
	task automatic t_purge();
		reset();
		wb(1, ADR_CTRL, 32'h00000103);
		wb(1, ADR_CFG, 32'h00000200);
		push(32'hD0000001);
		push(32'hD0000002);
		repeat (ACK_WAIT_CYC + 150) @(posedge clk_i);
		chk("presence wait", 1, n_ret);
		repeat (1200) @(posedge clk_i);
		chk("tries", 3, n_ret);
		wb(0, ADR_CNT, 0);
		chk("purges", 1, q[31:16]);
		wb(0, ADR_STAT, 0);
		chk("fifo empty", 0, q[4]);
	endtask
	task automatic t_odds();
		for (int o = 1; o <= 9; o += 8) begin
			reset();
			wb(1, ADR_CFG, o << 16);
			push(32'hE0000000);
			repeat (12000) @(posedge clk_i);
			if (o == 1) n1 = n_ret;
		end
		chk("odds order", 1, n_ret > n1);
		chk("random tries", 1, n1 > 1);
	endtask
	initial begin
		clk_i = 0;
		rst_i = 1;
		{cyc, stb, we, sin_v, clr, stall, adr, sel, wdat, sin_d} = '0;
		fail_count = 0;
		cmp_count = 0;
		reset();
		t_regs();
		t_master();
		t_slave();
		t_rep();
		t_ret();
		t_purge();
		t_odds();
		stop_test();
	end
endmodule

// ---- rtl/mlp_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides and flush
module mlp_fifo #(
	parameter int W = 32,
	parameter int D = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready_o = (count != (AW+1)'(D));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o && !flush_i;
	assign pop = out_valid_o && out_ready_i && !flush_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || flush_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ---- rtl/mlp_link.sv ----
// Multipoint link framer: master, repeater and slave packet handling
// Contract
// - Master broadcasts outbound data; slave sends only when serial data arrives.
// - Master or repeater sends each outbound packet repeatedly, unacknowledged.
// - Repeat setting 0..9 gives one to ten transmissions.
// - Receiver keeps first copy with good CRC and never acknowledges it.
// - Slave discards further copies of an already accepted packet.
// - Repeater drops remaining copies, then forwards the packet; the code starts forwarding as soon as the first good copy is accepted.
// - Repeater forwards using its own repeat setting.
// - Repeater acts as master downstream: broadcasts and acknowledges returns.
// - Return packets are acknowledged; sender retransmits until acknowledged.
// - Slave retries up to retry limit 0..9 before back-off.
// - After retries, slave attempts only on a random basis.
// - Retry odds sets attempt probability, higher value higher odds.
// - Odds zero: stop after retries and purge serial input buffer.
// - Repeater-presence setting 0 or 1 sets network timing.
// - Operation mode 7 makes the unit a repeater.
//
// Added by the designer: the placing of the registers and the Wishbone register port.
module mlp_link
	import mlp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial equipment side
	input wire logic ser_in_valid_i,
	output logic ser_in_ready_o,
	input wire logic [mlp_pkg::DATA_W-1:0] ser_in_data_i,
	output logic ser_out_valid_o,
	output logic [mlp_pkg::DATA_W-1:0] ser_out_data_o,
	// Radio transmit
	output logic rf_tx_valid_o,
	input wire logic rf_tx_ready_i,
	output logic [1:0] rf_tx_type_o,
	output logic [mlp_pkg::SEQ_W-1:0] rf_tx_seq_o,
	output logic [mlp_pkg::DATA_W-1:0] rf_tx_data_o,
	output logic [31:0] rf_tx_crc_o,
	// Radio receive
	input wire logic rf_rx_valid_i,
	input wire logic [1:0] rf_rx_type_i,
	input wire logic [mlp_pkg::SEQ_W-1:0] rf_rx_seq_i,
	input wire logic [mlp_pkg::DATA_W-1:0] rf_rx_data_i,
	input wire logic [31:0] rf_rx_crc_i
);
	import mlp_pkg::*;

	logic [3:0] mode;
	logic pres;
	logic [3:0] rep;
	logic [3:0] lim;
	logic [3:0] odds;
	logic [31:0] ctrl_rd;
	logic [31:0] cfg_rd;
	logic [31:0] next_ctrl;
	logic [31:0] next_cfg;
	logic wb_req;
	logic wb_wr;
	logic [15:0] dup_cnt;
	logic [15:0] purge_cnt;
	mlp_state_type state;
	logic [3:0] copies;
	logic [3:0] tries;
	logic [TMR_W-1:0] tmr;
	logic [TMR_W-1:0] wait_cyc;
	logic [SEQ_W-1:0] seq_cnt;
	logic [15:0] lfsr;
	logic [7:0] thr;
	logic purge;
	logic is_mst;
	logic is_slv;
	logic is_rep;
	logic is_hub;
	logic rx_good;
	logic out_new;
	logic out_dup;
	logic ret_in;
	logic ack_in;
	logic got_ack;
	logic have_seq;
	logic [SEQ_W-1:0] last_seq;
	logic ack_pend;
	logic [SEQ_W-1:0] ack_seq;
	logic fwd_pend;
	logic [SEQ_W-1:0] fwd_seq;
	logic [DATA_W-1:0] fwd_data;
	logic take_ack;
	logic take_fwd;
	logic take_new;
	logic tx_fire;
	logic fifo_v;
	logic [DATA_W-1:0] fifo_d;

	// Serial input buffer
	mlp_fifo #(
		.W(DATA_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flush_i(purge),
		.in_valid_i(ser_in_valid_i),
		.in_ready_o(ser_in_ready_o),
		.in_data_i(ser_in_data_i),
		.out_valid_o(fifo_v),
		.out_ready_i(take_new),
		.out_data_o(fifo_d)
	);

	// Role decode
	assign is_mst = (mode == MODE_MASTER);
	assign is_slv = (mode == MODE_SLAVE);
	assign is_rep = (mode == MODE_REPEATER);
	assign is_hub = is_mst || is_rep;

	// Bus slave
	assign wb_req = wb_cyc_i && wb_stb_i;
	assign wb_wr = wb_req && wb_we_i && wb_ack_o;

	always_comb begin
		ctrl_rd = '0;
		ctrl_rd[MODE_LSB +: 4] = mode;
		ctrl_rd[PRES_BIT] = pres;
		cfg_rd = '0;
		cfg_rd[REP_LSB +: 4] = rep;
		cfg_rd[LIM_LSB +: 4] = lim;
		cfg_rd[ODDS_LSB +: 4] = odds;
		next_ctrl = ctrl_rd;
		next_cfg = cfg_rd;
		for (int b = 0; b < 4; b++) begin
			if (wb_sel_i[b]) begin
				next_ctrl[8*b +: 8] = wb_dat_i[8*b +: 8];
				next_cfg[8*b +: 8] = wb_dat_i[8*b +: 8];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req && !wb_ack_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (wb_req && !wb_ack_o) begin
			case (wb_adr_i)
				ADR_CTRL: wb_dat_o <= ctrl_rd;
				ADR_CFG: wb_dat_o <= cfg_rd;
				ADR_STAT: wb_dat_o <= {8'h00, last_seq, tries, copies,
					ack_pend, fwd_pend, have_seq, fifo_v, 2'b00, state};
				ADR_CNT: wb_dat_o <= {purge_cnt, dup_cnt};
				default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= MODE_RST;
			pres <= PRES_RST;
		end else if (wb_wr && wb_adr_i == ADR_CTRL) begin
			mode <= next_ctrl[MODE_LSB +: 4];
			pres <= next_ctrl[PRES_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rep <= REP_RST;
			lim <= LIM_RST;
			odds <= ODDS_RST;
		end else if (wb_wr && wb_adr_i == ADR_CFG) begin
			rep <= mlp_clamp(next_cfg[REP_LSB +: 4]);
			lim <= mlp_clamp(next_cfg[LIM_LSB +: 4]);
			odds <= mlp_clamp(next_cfg[ODDS_LSB +: 4]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || (wb_wr && wb_adr_i == ADR_CNT)) begin
			dup_cnt <= 16'h0000;
			purge_cnt <= 16'h0000;
		end else begin
			if (out_dup) begin
				dup_cnt <= dup_cnt + 16'h0001;
			end
			if (purge) begin
				purge_cnt <= purge_cnt + 16'h0001;
			end
		end
	end

	// Receive classification
	assign rx_good = rf_rx_valid_i &&
		(rf_rx_crc_i == mlp_crc({rf_rx_type_i, rf_rx_seq_i, rf_rx_data_i}));
	assign out_dup = rx_good && rf_rx_type_i == FT_OUT && (is_slv || is_rep) &&
		have_seq && rf_rx_seq_i == last_seq;
	assign out_new = rx_good && rf_rx_type_i == FT_OUT && (is_slv || is_rep) &&
		!(have_seq && rf_rx_seq_i == last_seq);
	assign ret_in = rx_good && rf_rx_type_i == FT_RET && is_hub;
	assign ack_in = rx_good && rf_rx_type_i == FT_ACK && is_slv &&
		state == ST_WAIT && rf_rx_seq_i == rf_tx_seq_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			have_seq <= 1'b0;
			last_seq <= '0;
		end else if (out_new) begin
			have_seq <= 1'b1;
			last_seq <= rf_rx_seq_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ser_out_valid_o <= 1'b0;
			ser_out_data_o <= '0;
		end else begin
			ser_out_valid_o <= (out_new && is_slv) || ret_in;
			if ((out_new && is_slv) || ret_in) begin
				ser_out_data_o <= rf_rx_data_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			got_ack <= 1'b0;
		end else begin
			got_ack <= ack_in;
		end
	end

	// Pending acknowledge; a new return wins over the take
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_pend <= 1'b0;
			ack_seq <= '0;
		end else begin
			if (take_ack) begin
				ack_pend <= 1'b0;
			end
			if (ret_in) begin
				ack_pend <= 1'b1;
				ack_seq <= rf_rx_seq_i;
			end
		end
	end

	// Forward buffer of the repeater
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fwd_pend <= 1'b0;
			fwd_seq <= '0;
			fwd_data <= '0;
		end else begin
			if (take_fwd) begin
				fwd_pend <= 1'b0;
			end
			if (out_new && is_rep) begin
				fwd_pend <= 1'b1;
				fwd_seq <= rf_rx_seq_i;
				fwd_data <= rf_rx_data_i;
			end
		end
	end

	// Random source for back-off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lfsr <= LFSR_SEED;
		end else begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end

	assign thr = 8'(odds * ODDS_STEP);
	assign wait_cyc = pres ? TMR_W'(2 * ACK_WAIT_CYC) : TMR_W'(ACK_WAIT_CYC);

	// Transmit scheduling
	assign take_ack = state == ST_IDLE && ack_pend && is_hub;
	assign take_fwd = state == ST_IDLE && !take_ack && fwd_pend && is_rep;
	assign take_new = state == ST_IDLE && !take_ack && !take_fwd && fifo_v && !purge &&
		(is_mst || is_slv);
	assign tx_fire = rf_tx_valid_o && rf_tx_ready_i;
	assign rf_tx_crc_o = mlp_crc({rf_tx_type_o, rf_tx_seq_o, rf_tx_data_o});

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_cnt <= '0;
		end else if (take_new) begin
			seq_cnt <= seq_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			rf_tx_valid_o <= 1'b0;
			rf_tx_type_o <= FT_OUT;
			rf_tx_seq_o <= '0;
			rf_tx_data_o <= '0;
			copies <= 4'h0;
			tries <= 4'h0;
			tmr <= '0;
			purge <= 1'b0;
		end else begin
			purge <= 1'b0;
			case (state)
				ST_IDLE: begin
					copies <= 4'h0;
					tries <= 4'h0;
					if (take_ack) begin
						rf_tx_type_o <= FT_ACK;
						rf_tx_seq_o <= ack_seq;
						rf_tx_data_o <= '0;
						rf_tx_valid_o <= 1'b1;
						state <= ST_SEND;
					end else if (take_fwd) begin
						rf_tx_type_o <= FT_OUT;
						rf_tx_seq_o <= fwd_seq;
						rf_tx_data_o <= fwd_data;
						rf_tx_valid_o <= 1'b1;
						state <= ST_SEND;
					end else if (take_new) begin
						rf_tx_type_o <= is_mst ? FT_OUT : FT_RET;
						rf_tx_seq_o <= seq_cnt + 1'b1;
						rf_tx_data_o <= fifo_d;
						rf_tx_valid_o <= 1'b1;
						state <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (tx_fire) begin
						if (rf_tx_type_o == FT_OUT && copies < rep) begin
							copies <= copies + 4'h1;
						end else if (rf_tx_type_o == FT_RET) begin
							rf_tx_valid_o <= 1'b0;
							tmr <= wait_cyc;
							state <= ST_WAIT;
						end else begin
							rf_tx_valid_o <= 1'b0;
							state <= ST_IDLE;
						end
					end
				end
				ST_WAIT: begin
					if (got_ack) begin
						state <= ST_IDLE;
					end else if (tmr == '0) begin
						if (tries < lim) begin
							tries <= tries + 4'h1;
							rf_tx_valid_o <= 1'b1;
							state <= ST_SEND;
						end else if (odds == 4'h0) begin
							purge <= 1'b1;
							state <= ST_IDLE;
						end else begin
							tmr <= TMR_W'(SLOT_CYC);
							state <= ST_BACK;
						end
					end else begin
						tmr <= tmr - 1'b1;
					end
				end
				ST_BACK: begin
					if (tmr == '0) begin
						if (lfsr[7:0] < thr) begin
							rf_tx_valid_o <= 1'b1;
							state <= ST_SEND;
						end else begin
							tmr <= TMR_W'(SLOT_CYC);
						end
					end else begin
						tmr <= tmr - 1'b1;
					end
				end
				default: begin
					rf_tx_valid_o <= 1'b0;
					state <= ST_IDLE;
				end
			endcase
		end
	end

	property p_idle_slave;
		@(posedge clk_i) disable iff (rst_i)
		(is_slv && state == ST_IDLE && !fifo_v && !rf_tx_valid_o) |=> !rf_tx_valid_o;
	endproperty
	a_idle_slave: assert property (p_idle_slave) else $error("slave sent without data");

	property p_copy_count;
		@(posedge clk_i) disable iff (rst_i)
		(tx_fire && rf_tx_type_o == FT_OUT && copies < rep) |=>
			(rf_tx_valid_o && copies == $past(copies) + 4'h1);
	endproperty
	a_copy_count: assert property (p_copy_count) else $error("outbound copy not repeated");

	property p_rep_range;
		@(posedge clk_i) disable iff (rst_i)
		copies <= rep && rep <= SET_MAX;
	endproperty
	a_rep_range: assert property (p_rep_range) else $error("repeat count out of range");

	property p_no_ack_out;
		@(posedge clk_i) disable iff (rst_i)
		(rx_good && rf_rx_type_i == FT_OUT && !ack_pend) |=> !ack_pend;
	endproperty
	a_no_ack_out: assert property (p_no_ack_out) else $error("outbound packet acknowledged");

	property p_dup_drop;
		@(posedge clk_i) disable iff (rst_i)
		(out_dup && !ret_in) |=> !ser_out_valid_o;
	endproperty
	a_dup_drop: assert property (p_dup_drop) else $error("duplicate copy delivered");

	property p_fwd_take;
		@(posedge clk_i) disable iff (rst_i)
		(is_rep && out_new) |=> fwd_pend && fwd_seq == $past(rf_rx_seq_i);
	endproperty
	a_fwd_take: assert property (p_fwd_take) else $error("repeater lost accepted packet");

	property p_ack_done;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_WAIT && got_ack) |=> state == ST_IDLE;
	endproperty
	a_ack_done: assert property (p_ack_done) else $error("acknowledge not honoured");

	property p_tries_cap;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_WAIT && tmr == '0 && !got_ack && tries == lim) |=> state != ST_SEND;
	endproperty
	a_tries_cap: assert property (p_tries_cap) else $error("retry limit exceeded");

	property p_odds_block;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_BACK && tmr == '0 && lfsr[7:0] >= thr) |=>
			(state == ST_BACK && tmr == TMR_W'(SLOT_CYC));
	endproperty
	a_odds_block: assert property (p_odds_block) else $error("back-off odds ignored");

	property p_purge;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_WAIT && tmr == '0 && !got_ack && tries == lim && odds == 4'h0) |=>
			(purge && state == ST_IDLE);
	endproperty
	a_purge: assert property (p_purge) else $error("buffer not purged");
endmodule

// ---- rtl/mlp_pkg.sv ----
// Shared constants, types and helpers of the multipoint link framer
package mlp_pkg;
	localparam int DATA_W = 32;
	localparam int SEQ_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int TMR_W = 10;
	// Register offsets
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_CFG = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;
	localparam logic [7:0] ADR_CNT = 8'h0C;
	// Field positions
	localparam int MODE_LSB = 0;
	localparam int PRES_BIT = 8;
	localparam int REP_LSB = 0;
	localparam int LIM_LSB = 8;
	localparam int ODDS_LSB = 16;
	// Reset values
	localparam logic [3:0] MODE_RST = 4'h3;
	localparam logic PRES_RST = 1'b0;
	localparam logic [3:0] REP_RST = 4'h3;
	localparam logic [3:0] LIM_RST = 4'h9;
	localparam logic [3:0] ODDS_RST = 4'h9;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	// Operation modes and setting range
	localparam logic [3:0] MODE_MASTER = 4'h2;
	localparam logic [3:0] MODE_SLAVE = 4'h3;
	localparam logic [3:0] MODE_REPEATER = 4'h7;
	localparam logic [3:0] SET_MAX = 4'h9;
	localparam logic [7:0] ODDS_STEP = 8'h1A;
	// Frame types
	localparam logic [1:0] FT_OUT = 2'h0;
	localparam logic [1:0] FT_RET = 2'h1;
	localparam logic [1:0] FT_ACK = 2'h2;
	// Timing
	localparam int CLK_NS = 8;
	localparam int ACK_WAIT_NS = 2000;
	localparam int SLOT_NS = 1000;
	localparam int ACK_WAIT_CYC = (ACK_WAIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int SLOT_CYC = (SLOT_NS + CLK_NS - 1) / CLK_NS;
	// CRC-32
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_WAIT = 2'b10,
		ST_BACK = 2'b11
	} mlp_state_type;

	function automatic logic [31:0] mlp_crc(input logic [41:0] d);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 41; i >= 0; i--) begin
			c = (c << 1) ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h00000000);
		end
		return ~c;
	endfunction

	function automatic logic [3:0] mlp_clamp(input logic [3:0] v);
		return (v > SET_MAX) ? SET_MAX : v;
	endfunction
endpackage
